// ==== src/scc_top.sv ====
// secondary channel 3/4 with counter clearing synchronised to primary flags
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
//----------------------------------------------------------------
//----------------------------------------------------------------
module scc_top #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic [7:0] primaryFlags,
  input wire logic ch4TroughEvent,
  output logic [3:0] cmpIrq,
  output logic overflowIrq,
  output logic convTrigger,
  output logic convTriggerTrough,
  output logic [3:0] primaryCh0APriority,
  output logic [3:0] ch4PinOut,
  output logic [CNT_W-1:0] ch4Count,
  output logic [CNT_W-1:0] ch3Count
);
  //----------------------------------------------------------------
  // reset release
  //----------------------------------------------------------------
  logic rstMeta;
  logic rstB;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta <= 1'b0;
      rstB <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstB <= rstMeta;
    end
  end

  //----------------------------------------------------------------
  // registers
  //----------------------------------------------------------------
  logic [7:0] ch4IoCtrlHigh;
  logic [7:0] ch4IoCtrlLow;
  logic [7:0] ch4IrqEnable;
  logic [7:0] secondaryStart;
  scc_pkg::scc_flags_s syncClearSelect;
  logic [15:0] irqPriorityD;
  logic [2:0] clearSourceSel;
  scc_pkg::scc_cmp_s cmpFlag;
  logic overflowFlag;
  scc_pkg::scc_bus_e busState;
  logic wrEn;

  assign wrEn = (busState == scc_pkg::BUS_DONE) && avsWrite;

  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
    begin
      ch4IoCtrlHigh <= scc_pkg::RST_BYTE;
      ch4IoCtrlLow <= scc_pkg::RST_BYTE;
      ch4IrqEnable <= scc_pkg::RST_BYTE;
      secondaryStart <= scc_pkg::RST_BYTE;
      syncClearSelect <= scc_pkg::RST_BYTE;
      irqPriorityD <= scc_pkg::RST_PRIORITY;
      clearSourceSel <= scc_pkg::RST_CLEAR_SOURCE;
    end
    else if (wrEn)
    begin
      case (avsAddress)
        scc_pkg::ADDR_CH4_IO_CTRL_HIGH:
          if (avsByteEnable[0]) ch4IoCtrlHigh <= avsWriteData[7:0];
        scc_pkg::ADDR_CH4_IO_CTRL_LOW:
          if (avsByteEnable[0]) ch4IoCtrlLow <= avsWriteData[7:0];
        scc_pkg::ADDR_CH4_IRQ_ENABLE:
          if (avsByteEnable[0])
            ch4IrqEnable <= avsWriteData[7:0] & scc_pkg::IRQ_EN_WRITE_MASK;
        scc_pkg::ADDR_SECONDARY_START:
          if (avsByteEnable[0])
            secondaryStart <= avsWriteData[7:0] & scc_pkg::START_WRITE_MASK;
        scc_pkg::ADDR_SYNC_CLEAR_SELECT:
          if (avsByteEnable[0]) syncClearSelect <= avsWriteData[7:0];
        scc_pkg::ADDR_IRQ_PRIORITY_D:
        begin
          if (avsByteEnable[0]) irqPriorityD[7:0] <= avsWriteData[7:0];
          if (avsByteEnable[1]) irqPriorityD[15:8] <= avsWriteData[15:8];
        end
        scc_pkg::ADDR_CH4_CLEAR_SOURCE:
          if (avsByteEnable[0]) clearSourceSel <= avsWriteData[2:0];
        default:
        begin
        end
      endcase
    end
  end

  //----------------------------------------------------------------
  // bus slave: two wait cycles (idle, then BUS_WAIT), then answer
  //----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
      busState <= scc_pkg::BUS_IDLE;
    else
    begin
      case (busState)
        scc_pkg::BUS_IDLE:
          if (avsRead || avsWrite) busState <= scc_pkg::BUS_WAIT;
        scc_pkg::BUS_WAIT:
          busState <= scc_pkg::BUS_DONE;
        scc_pkg::BUS_DONE:
          busState <= scc_pkg::BUS_IDLE;
        default:
          busState <= scc_pkg::BUS_IDLE;
      endcase
    end
  end

  logic [31:0] next_readData;

  always_comb
  begin
    next_readData = 32'h0000_0000;
    case (avsAddress)
      scc_pkg::ADDR_CH4_IO_CTRL_HIGH: next_readData[7:0] = ch4IoCtrlHigh;
      scc_pkg::ADDR_CH4_IO_CTRL_LOW: next_readData[7:0] = ch4IoCtrlLow;
      scc_pkg::ADDR_CH4_IRQ_ENABLE: next_readData[7:0] = ch4IrqEnable;
      scc_pkg::ADDR_SECONDARY_START: next_readData[7:0] = secondaryStart;
      scc_pkg::ADDR_SYNC_CLEAR_SELECT: next_readData[7:0] = syncClearSelect;
      scc_pkg::ADDR_IRQ_PRIORITY_D: next_readData[15:0] = irqPriorityD;
      scc_pkg::ADDR_CH4_CLEAR_SOURCE: next_readData[2:0] = clearSourceSel;
      scc_pkg::ADDR_CH4_COUNTER: next_readData[CNT_W-1:0] = ch4Count;
      scc_pkg::ADDR_CH3_COUNTER: next_readData[CNT_W-1:0] = ch3Count;
      scc_pkg::ADDR_CH4_STATUS: next_readData[4:0] = {overflowFlag, cmpFlag};
      default: next_readData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
    begin
      avsReadData <= 32'h0000_0000;
      avsWaitRequest <= 1'b1;
    end
    else
    begin
      avsWaitRequest <= !(busState == scc_pkg::BUS_WAIT);
      if (busState == scc_pkg::BUS_WAIT && avsRead)
        avsReadData <= next_readData;
    end
  end

  //----------------------------------------------------------------
  // synchronous clear from primary flags
  //----------------------------------------------------------------
  logic [7:0] flagLevel;
  logic [7:0] flagRise;
  logic syncClear;

  scc_edge_sync #(
    .WIDTH(8)
  ) u_flags (
    .clk(clk),
    .rstB(rstB),
    .din(primaryFlags),
    .level(flagLevel),
    .rise(flagRise)
  );

  // select bit n pairs with flag bit n, bit 7 is ch0 flag A
  assign syncClear = |(flagRise & syncClearSelect);

  //----------------------------------------------------------------
  // counters
  //----------------------------------------------------------------
  logic ch4ClearBySync;
  logic ch4Match;
  logic [CNT_W-1:0] ch4CmpA;

  assign ch4ClearBySync = syncClear && clearSourceSel == scc_pkg::CLR_SRC_SYNC;
  assign ch4CmpA = {CNT_W{1'b1}};
  assign ch4Match = ch4Count == ch4CmpA;

  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
      ch4Count <= '0;
    else if (ch4ClearBySync)
      ch4Count <= '0;
    else if (secondaryStart[scc_pkg::RUN_CH4_BIT])
      ch4Count <= ch4Count + 1'b1;
  end

  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
      ch3Count <= '0;
    else if (syncClear)
      ch3Count <= '0;
    else if (secondaryStart[scc_pkg::RUN_CH3_BIT])
      ch3Count <= ch3Count + 1'b1;
  end

  //----------------------------------------------------------------
  // ch4 flags, requests and pins
  //----------------------------------------------------------------
  logic ch4Overflow;
  logic ch4Running;

  assign ch4Running = secondaryStart[scc_pkg::RUN_CH4_BIT] && !ch4ClearBySync;
  assign ch4Overflow = ch4Running && ch4Match;

  // overflow flag set on overflow, compare flags never set; reading status clears, a new overflow wins
  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
    begin
      overflowFlag <= 1'b0;
      cmpFlag <= '0;
    end
    else
    begin
      if (busState == scc_pkg::BUS_DONE && avsRead && avsAddress == scc_pkg::ADDR_CH4_STATUS)
      begin
        overflowFlag <= 1'b0;
        cmpFlag <= '0;
      end
      if (ch4Overflow)
        overflowFlag <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
    begin
      cmpIrq <= '0;
      overflowIrq <= 1'b0;
      convTrigger <= 1'b0;
      convTriggerTrough <= 1'b0;
      primaryCh0APriority <= '0;
      ch4PinOut <= '0;
    end
    else
    begin
      cmpIrq <= cmpFlag & ch4IrqEnable[3:0];
      overflowIrq <= overflowFlag && ch4IrqEnable[4];
      convTrigger <= (|cmpFlag) && ch4IrqEnable[7];
      convTriggerTrough <= ch4TroughEvent && ch4IrqEnable[6];
      primaryCh0APriority <= irqPriorityD[15:12];
      // mode 0000 keeps each pin at its current level
      if (ch4IoCtrlHigh[3:0] != scc_pkg::IO_MODE_CMP_HOLD) ch4PinOut[0] <= 1'b0;
      if (ch4IoCtrlHigh[7:4] != scc_pkg::IO_MODE_CMP_HOLD) ch4PinOut[1] <= 1'b0;
      if (ch4IoCtrlLow[3:0] != scc_pkg::IO_MODE_CMP_HOLD) ch4PinOut[2] <= 1'b0;
      if (ch4IoCtrlLow[7:4] != scc_pkg::IO_MODE_CMP_HOLD) ch4PinOut[3] <= 1'b0;
    end
  end

  //----------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------
  sequence flagRiseA_s;
    flagRise[7] && syncClearSelect[7] && clearSourceSel == scc_pkg::CLR_SRC_SYNC;
  endsequence

  clear_on_a_a: assert property (@(posedge clk) disable iff (!rstB)
    flagRiseA_s |=> ch4Count == '0)
    else $error("ch4 counter not cleared on flag A");
  select_off_a: assert property (@(posedge clk) disable iff (!rstB)
    (flagRise & ~syncClearSelect) != 0 && (flagRise & syncClearSelect) == 0
      && secondaryStart[6] && ch3Count != {CNT_W{1'b1}} |=> ch3Count != '0)
    else $error("disabled source cleared ch3");
  ch3_clear_a: assert property (@(posedge clk) disable iff (!rstB)
    syncClear |=> ch3Count == '0)
    else $error("ch3 not cleared on sync clear");
  run_stop_a: assert property (@(posedge clk) disable iff (!rstB)
    !secondaryStart[7] && !ch4ClearBySync |=> $stable(ch4Count))
    else $error("ch4 counted while stopped");
  start_rsvd_a: assert property (@(posedge clk) disable iff (!rstB)
    secondaryStart[5:0] == 6'h00)
    else $error("reserved start bits set");
  ovf_gate_a: assert property (@(posedge clk) disable iff (!rstB)
    overflowIrq |-> $past(overflowFlag) && $past(ch4IrqEnable[4]))
    else $error("overflow request not gated");
  cmp_gate_a: assert property (@(posedge clk) disable iff (!rstB)
    ##1 cmpIrq == ($past(cmpFlag) & $past(ch4IrqEnable[3:0])))
    else $error("compare request mismatch");
  en_rsvd_a: assert property (@(posedge clk) disable iff (!rstB)
    !ch4IrqEnable[5])
    else $error("reserved enable bit set");
  prio_a: assert property (@(posedge clk) disable iff (!rstB)
    ##1 primaryCh0APriority == $past(irqPriorityD[15:12]))
    else $error("priority field mismatch");
  once_a: assert property (@(posedge clk) disable iff (!rstB)
    syncClear |-> (flagRise & syncClearSelect & ~$past(flagLevel)) != 8'h00)
    else $error("sync clear from a flag that was already set");
endmodule
`default_nettype wire

// ==== src/scc_pkg.sv ====
// package: register map, field layout and constants of the sync counter clear channel
package scc_pkg;

  // ----------------------------------------------------------------
  // register map (word addresses, one register per consecutive index)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CH4_IO_CTRL_HIGH = 4'h0;
  localparam logic [3:0] ADDR_CH4_IO_CTRL_LOW = 4'h1;
  localparam logic [3:0] ADDR_CH4_IRQ_ENABLE = 4'h2;
  localparam logic [3:0] ADDR_SECONDARY_START = 4'h3;
  localparam logic [3:0] ADDR_SYNC_CLEAR_SELECT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_PRIORITY_D = 4'h5;
  localparam logic [3:0] ADDR_CH4_CLEAR_SOURCE = 4'h6;
  localparam logic [3:0] ADDR_CH4_COUNTER = 4'h7;
  localparam logic [3:0] ADDR_CH3_COUNTER = 4'h8;
  localparam logic [3:0] ADDR_CH4_STATUS = 4'h9;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_PRIORITY = 16'h0000;
  localparam logic [2:0] RST_CLEAR_SOURCE = 3'h0;
  localparam logic [7:0] START_WRITE_MASK = 8'hc0;
  localparam logic [7:0] IRQ_EN_WRITE_MASK = 8'hdf;
  localparam int RUN_CH4_BIT = 7;
  localparam int RUN_CH3_BIT = 6;
  localparam logic [3:0] IO_MODE_CMP_HOLD = 4'h0;
  localparam logic [2:0] CLR_SRC_SYNC = 3'h3;
  localparam logic [2:0] CLR_SRC_CMP_A = 3'h1;
  localparam logic [1:0] WAIT_CYCLES = 2'h1;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cmpD;
    logic cmpC;
    logic cmpB;
    logic cmpA;
  } scc_cmp_s;

  // primary flags in sync_clear_select bit order, bit 7 first
  typedef struct packed {
    logic ch0A;
    logic ch0B;
    logic ch0C;
    logic ch0D;
    logic ch1A;
    logic ch1B;
    logic ch2A;
    logic ch2B;
  } scc_flags_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WAIT = 2'b01,
    BUS_DONE = 2'b11
  } scc_bus_e;

endpackage

// ==== src/scc_edge_sync.sv ====
// two-flop synchroniser with one-shot rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module scc_edge_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rstB,
  input wire logic [WIDTH-1:0] din,
  output var logic [WIDTH-1:0] level,
  output var logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] prev;

  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
    begin
      meta <= '0;
      level <= '0;
      prev <= '0;
    end
    else
    begin
      meta <= din;
      level <= meta;
      prev <= level;
    end
  end

  // one pulse per clear-to-set change, a held flag gives nothing more
  always_comb
  begin
    rise = level & ~prev;
  end
endmodule
`default_nettype wire

// ==== bench/scc_primary_model.sv ====
// partner model: primary timer compare flags feeding the sync clear logic
`timescale 1ns/1ps
`default_nettype none
module scc_primary_model (
  input wire logic clk,
  input wire logic rstB,
  input wire logic [7:0] raise,
  input wire logic drop,
  output logic [7:0] primaryFlags
);
  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
      primaryFlags <= 8'h00;
    else if (drop)
      primaryFlags <= 8'h00;
    else
      primaryFlags <= primaryFlags | raise;
  end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench of the sync counter clear channel
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst_b, avsRead, avsWrite, avsWaitRequest, drop, trough;
  logic ovf, cnv, cnvT, seen;
  logic [3:0] avsAddress, avsByteEnable, cmpIrq, pri, pin;
  logic [31:0] avsWriteData, avsReadData, rd, lfsr, d;
  logic [7:0] raise, flags;
  logic [15:0] c4, c3, hold;
  int miscompares, checks, o;

  scc_primary_model scc_primary_model_i (.clk(clk), .rstB(rst_b), .raise(raise),
    .drop(drop), .primaryFlags(flags));
  scc_top scc_top_i (.clk(clk), .rst_b(rst_b), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .primaryFlags(flags),
    .ch4TroughEvent(trough), .cmpIrq(cmpIrq), .overflowIrq(ovf), .convTrigger(cnv),
    .convTriggerTrough(cnvT), .primaryCh0APriority(pri), .ch4PinOut(pin),
    .ch4Count(c4), .ch3Count(c3));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] nextRand(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  function automatic logic [31:0] maskOf(input int a);
    case (a)
      2: return 32'hdf;
      3: return 32'hc0;
      5: return 32'hffff;
      6: return 32'h7;
      default: return 32'hff;
    endcase
  endfunction

  task automatic chkEq(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkRange(input string nm, input int lo, input int hi, input logic [15:0] g);
    checks++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      miscompares++;
      $display("[ERR] %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask

  // avalon access: hold request until waitrequest is sampled low
  task automatic avAccess(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk);
    avsAddress <= a;
    avsWriteData <= wd;
    avsWrite <= wr;
    avsRead <= !wr;
    do
    begin
      @(posedge clk);
    end
    while (avsWaitRequest !== 1'b0);
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask

  task automatic syncCase(input logic [7:0] r, input logic clr4, input logic clr3);
    repeat (20) @(posedge clk);
    raise <= r;
    @(posedge clk);
    raise <= 8'h00;
    repeat (6) @(posedge clk);
    chkRange("ch4Count", clr4 ? 0 : 20, clr4 ? 8 : 65535, c4);
    chkRange("ch3Count", clr3 ? 0 : 20, clr3 ? 8 : 65535, c3);
    repeat (12) @(posedge clk);
    chkRange("ch4Count run on", 10, 65535, c4);
    drop <= 1'b1;
    @(posedge clk);
    drop <= 1'b0;
  endtask

  task automatic troughCase(input logic [31:0] en, input logic exp);
    avAccess(1'b1, 4'h2, en);
    trough <= 1'b1;
    @(posedge clk);
    trough <= 1'b0;
    seen = 1'b0;
    repeat (5) @(posedge clk) seen = seen | (cnvT === 1'b1);
    chkEq("convTriggerTrough", {31'h0, exp}, {31'h0, seen});
    chkEq("convTrigger", 32'h0, {31'h0, cnv});
    chkEq("cmpIrq", 32'h0, {28'h0, cmpIrq});
    chkEq("overflowIrq", 32'h0, {31'h0, ovf});
  endtask

  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #200000;
    miscompares++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsAddress = 4'h0;
    avsWriteData = 32'h0;
    avsByteEnable = 4'hf;
    raise = 8'h00;
    drop = 1'b0;
    trough = 1'b0;
    lfsr = 32'd77060;
    miscompares = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    for (int a = 0; a < 7; a++)
    begin
      avAccess(1'b0, a[3:0], 32'h0);
      chkEq("reset value", 32'h0, rd);
      lfsr = nextRand(lfsr);
      d = lfsr;
      avAccess(1'b1, a[3:0], d);
      avAccess(1'b0, a[3:0], 32'h0);
      chkEq("register readback", d & maskOf(a), rd);
      avAccess(1'b1, a[3:0], 32'h0);
    end
    avAccess(1'b1, 4'hf, 32'hff);
    avAccess(1'b0, 4'hf, 32'h0);
    chkEq("unmapped read", 32'h0, rd);
    avAccess(1'b1, 4'h5, 32'hf000);
    repeat (2) @(posedge clk);
    chkEq("priority ch0 A", 32'hf, {28'h0, pri});
    chkEq("ch4 pins held", 32'h0, {28'h0, pin});
    troughCase(32'h5f, 1'b1);
    troughCase(32'h9f, 1'b0);
    avAccess(1'b1, 4'h6, 32'h3);
    avAccess(1'b1, 4'h3, 32'hc0);
    for (int b = 0; b < 8; b++)
    begin
      avAccess(1'b1, 4'h4, 32'h1 << b);
      syncCase(8'h01 << b, 1'b1, 1'b1);
      lfsr = nextRand(lfsr);
      o = (b + 1 + lfsr[15:0] % 7) % 8;
      syncCase(8'h01 << o, 1'b0, 1'b0);
    end
    avAccess(1'b1, 4'h6, 32'h0);
    avAccess(1'b1, 4'h4, 32'hff);
    syncCase(8'h80, 1'b0, 1'b1);
    avAccess(1'b1, 4'h3, 32'h40);
    @(posedge clk);
    hold = c4;
    repeat (8) @(posedge clk);
    chkEq("ch4 stopped", {16'h0, hold}, {16'h0, c4});
    avAccess(1'b0, 4'h7, 32'h0);
    chkEq("ch4 count read", {16'h0, hold}, rd);
    avAccess(1'b0, 4'h9, 32'h0);
    chkEq("ch4 status", 32'h0, rd);
    chkRange("ch3 running", 8, 65535, c3);
    finish_test();
  end
endmodule
`default_nettype wire
